// ### safety_telegram_words.sv
// Purpose: command and state words of the safety telegram, device end
// Assumes: telegram words arrive on CLK_SYS with a one-cycle valid strobe
// Notes: inverter-side status inputs are already on CLK_SYS
//   requests stand between telegrams; torque off is requested out of reset
//
// Functional notes
// - input state bit 8 follows the first fail-safe input pair level.
// - input state bit 9 follows the second fail-safe input pair level.
// - input state bit 10 follows the third fail-safe input pair level.
// - an unused or discrepancy-deactivated input reads zero.
// - words two exist only in the extended telegram variant.
// - power-removed bit is one only once torque is safely off.
// - stop-one-active bit is one while the stop ramp runs, in the extended variant only.
// - limited-speed-active bit is one while limiting is requested and speed sits below the limit.
// - internal-event bit is one after an internal fault stop.
// - state word reports the speed-limit level in force; the basic variant reports level one.
`timescale 1ns/1ns
`default_nettype none
module safety_telegram_words #(
  parameter int PAIRS = safety_telegram_pkg::INPUT_PAIRS,
  parameter int DISC_CYCLES = safety_telegram_pkg::DISCREPANCY_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // telegram from the controller
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic [15:0] CMD_WORD_TWO,
  input wire logic EXTENDED_TELEGRAM,
  // telegram to the controller
  output logic [15:0] STATE_WORD,
  output logic [15:0] INPUT_STATE_WORD,
  // fail-safe input pins and configuration
  input wire logic [PAIRS-1:0] FAILSAFE_CH_A,
  input wire logic [PAIRS-1:0] FAILSAFE_CH_B,
  input wire logic [PAIRS-1:0] FAILSAFE_INPUT_USED,
  // inverter drive status
  input wire logic TORQUE_SAFELY_OFF,
  input wire logic STOP_ONE_RAMPING,
  input wire logic SPEED_BELOW_LIMIT,
  input wire logic INTERNAL_FAULT_STOP,
  // function requests to the inverter
  output logic SAFE_TORQUE_OFF_REQ,
  output logic SAFE_STOP_ONE_REQ,
  output logic LIMITED_SPEED_REQ,
  output logic [1:0] LIMITED_SPEED_LEVEL,
  output logic EVENT_ACK_PULSE,
  output logic [PAIRS-1:0] FAILSAFE_INPUT_DEACT
);

  // ----------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------
  logic [15:0] cmd_q, cmd_d;
  logic ack_prev_q, ack_prev_d;
  logic ack_pulse_q, ack_pulse_d;
  logic ext_q, ext_d;
  safety_telegram_pkg::cmd_fields_t cmd_f;
  safety_telegram_pkg::cmd_fields_t new_f;
  logic cmd_two_unused;

  // ----------------------------------------------------------------
  // command word two
  // ----------------------------------------------------------------
  // command word two has no function; its content is never looked at
  assign cmd_two_unused = ^CMD_WORD_TWO;

  // ----------------------------------------------------------------
  // command word decode
  // ----------------------------------------------------------------
  // select bits flip here, so an all-zero word selects every function
  function automatic safety_telegram_pkg::cmd_fields_t decode_cmd(
    input logic [15:0] w
  );
    safety_telegram_pkg::cmd_fields_t f;
    f.torque_off_sel = !w[safety_telegram_pkg::CMD_TORQUE_OFF_BIT];
    f.stop_one_sel = !w[safety_telegram_pkg::CMD_STOP_ONE_BIT];
    f.limited_speed_sel = !w[safety_telegram_pkg::CMD_LIMITED_SPEED_BIT];
    f.event_ack = w[safety_telegram_pkg::CMD_EVENT_ACK_BIT];
    f.level = safety_telegram_pkg::speed_level_t'(w[safety_telegram_pkg::CMD_LEVEL_LSB +: 2]);
    return f;
  endfunction

  // ----------------------------------------------------------------
  // command register and acknowledge edge
  // ----------------------------------------------------------------
  always_comb begin
    new_f = decode_cmd(CMD_WORD);
    cmd_d = cmd_q;
    ack_prev_d = ack_prev_q;
    ack_pulse_d = 1'b0;
    ext_d = EXTENDED_TELEGRAM;
    if (CMD_VALID) begin
      cmd_d = CMD_WORD;
      ack_prev_d = new_f.event_ack;
      // only the falling change acknowledges; a steady one does nothing
      ack_pulse_d = ack_prev_q && !new_f.event_ack;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cmd_q <= safety_telegram_pkg::CMD_RESET;
      ack_prev_q <= 1'b0;
      ack_pulse_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      ack_prev_q <= ack_prev_d;
      ack_pulse_q <= ack_pulse_d;
      ext_q <= ext_d;
    end
  end

  // decoded from the held word, never from the bus, so requests stand
  assign cmd_f = decode_cmd(cmd_q);

  // ----------------------------------------------------------------
  // function requests
  // ----------------------------------------------------------------
  logic sto_req_q, sto_req_d;
  logic ss1_req_q, ss1_req_d;
  logic sls_req_q, sls_req_d;

  always_comb begin
    // zero in a select bit requests the function
    sto_req_d = cmd_f.torque_off_sel;
    // the basic variant carries torque off only
    ss1_req_d = ext_q && cmd_f.stop_one_sel;
    sls_req_d = ext_q && cmd_f.limited_speed_sel;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      // torque off out of reset: the safe state until a telegram arrives
      sto_req_q <= 1'b1;
      ss1_req_q <= 1'b0;
      sls_req_q <= 1'b0;
    end else begin
      sto_req_q <= sto_req_d;
      ss1_req_q <= ss1_req_d;
      sls_req_q <= sls_req_d;
    end
  end

  // ----------------------------------------------------------------
  // speed-limit level
  // ----------------------------------------------------------------
  logic [1:0] level_q, level_d;

  always_comb begin
    level_d = level_q;
    // level is taken while limiting is off, so it cannot jump mid-limit
    if (!sls_req_q || !sls_req_d) begin
      level_d = cmd_f.level;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      level_q <= safety_telegram_pkg::LEVEL_ONE;
    end else begin
      level_q <= level_d;
    end
  end

  // ----------------------------------------------------------------
  // internal event flag
  // ----------------------------------------------------------------
  // sticky until acknowledged, so a short fault stop is never lost
  logic event_q, event_d;

  always_comb begin
    event_d = event_q;
    if (ack_pulse_q) begin
      event_d = 1'b0;
    end
    // a fault in the acknowledge cycle keeps the flag set
    if (INTERNAL_FAULT_STOP) begin
      event_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_d;
    end
  end

  // ----------------------------------------------------------------
  // fail-safe input pairs
  // ----------------------------------------------------------------
  logic [PAIRS-1:0] pair_level;
  logic [PAIRS-1:0] pair_deact;
  logic [PAIRS-1:0] deact_q, deact_d;

  // one filter per pair; the event acknowledge also clears deactivation
  genvar gi;
  generate
    for (gi = 0; gi < PAIRS; gi++) begin : g_pair
      failsafe_input_pair #(
        .DISC_CYCLES(DISC_CYCLES)
      ) u_pair (
        .clk(CLK_SYS),
        .reset(RESET),
        .ch_a_pin(FAILSAFE_CH_A[gi]),
        .ch_b_pin(FAILSAFE_CH_B[gi]),
        .used(FAILSAFE_INPUT_USED[gi]),
        .clear_deact(ack_pulse_q),
        .level(pair_level[gi]),
        .deactivated(pair_deact[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // deactivation report
  // ----------------------------------------------------------------
  always_comb begin
    deact_d = pair_deact;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      deact_q <= '0;
    end else begin
      deact_q <= deact_d;
    end
  end

  // ----------------------------------------------------------------
  // state words
  // ----------------------------------------------------------------
  logic [15:0] state_q, state_d;
  safety_telegram_pkg::state_fields_t sf;

  always_comb begin
    sf.power_removed = TORQUE_SAFELY_OFF;
    sf.stop_one_active = ext_q && STOP_ONE_RAMPING;
    // no limit bit unless limiting is requested
    sf.limited_speed_active = ext_q && sls_req_q && SPEED_BELOW_LIMIT;
    sf.internal_event = event_q;
    sf.level = ext_q ? safety_telegram_pkg::speed_level_t'(level_q) :
               safety_telegram_pkg::LEVEL_ONE;
    state_d = safety_telegram_pkg::STATE_RESET;
    state_d[safety_telegram_pkg::STA_POWER_REMOVED_BIT] = sf.power_removed;
    state_d[safety_telegram_pkg::STA_STOP_ONE_BIT] = sf.stop_one_active;
    state_d[safety_telegram_pkg::STA_LIMITED_SPEED_BIT] = sf.limited_speed_active;
    state_d[safety_telegram_pkg::STA_INTERNAL_EVENT_BIT] = sf.internal_event;
    state_d[safety_telegram_pkg::STA_LEVEL_LSB +: 2] = sf.level;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q <= safety_telegram_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // input state word
  // ----------------------------------------------------------------
  logic [15:0] inp_q, inp_d;

  always_comb begin
    inp_d = safety_telegram_pkg::INPUT_STATE_RESET;
    // word two reads zero in the basic variant
    if (ext_q) begin
      inp_d[safety_telegram_pkg::INP_FIRST_PAIR_BIT] = pair_level[0];
      inp_d[safety_telegram_pkg::INP_FIRST_PAIR_BIT + 1] = pair_level[1];
      inp_d[safety_telegram_pkg::INP_FIRST_PAIR_BIT + 2] = pair_level[2];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      inp_q <= safety_telegram_pkg::INPUT_STATE_RESET;
    end else begin
      inp_q <= inp_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every pin is a flop output, so the telegram never carries a glitch
  assign STATE_WORD = state_q;
  assign INPUT_STATE_WORD = inp_q;
  assign SAFE_TORQUE_OFF_REQ = sto_req_q;
  assign SAFE_STOP_ONE_REQ = ss1_req_q;
  assign LIMITED_SPEED_REQ = sls_req_q;
  assign LIMITED_SPEED_LEVEL = level_q;
  assign EVENT_ACK_PULSE = ack_pulse_q;
  assign FAILSAFE_INPUT_DEACT = deact_q;

endmodule
`default_nettype wire

// ### safety_telegram_pkg.sv
// Purpose: shared constants and carriers for the safety telegram words
// Assumes: 16-bit words, bit 0 is the least significant bit
// Notes: offsets below are bit positions within each word
package safety_telegram_pkg;

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int INPUT_PAIRS = 3;

  // ----------------------------------------------------------------
  // command word bit positions
  // ----------------------------------------------------------------
  localparam int CMD_TORQUE_OFF_BIT = 0;
  localparam int CMD_STOP_ONE_BIT = 1;
  localparam int CMD_LIMITED_SPEED_BIT = 4;
  localparam int CMD_EVENT_ACK_BIT = 7;
  localparam int CMD_LEVEL_LSB = 9;

  // ----------------------------------------------------------------
  // state word bit positions
  // ----------------------------------------------------------------
  localparam int STA_POWER_REMOVED_BIT = 0;
  localparam int STA_STOP_ONE_BIT = 1;
  localparam int STA_LIMITED_SPEED_BIT = 4;
  localparam int STA_INTERNAL_EVENT_BIT = 7;
  localparam int STA_LEVEL_LSB = 9;

  // ----------------------------------------------------------------
  // input state word bit positions
  // ----------------------------------------------------------------
  localparam int INP_FIRST_PAIR_BIT = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // all function-select bits at zero: every function selected, torque off
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] STATE_RESET = 16'h0000;
  localparam logic [15:0] INPUT_STATE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int DISCREPANCY_TIME_US = 1000;
  localparam int DISCREPANCY_CYCLES = (DISCREPANCY_TIME_US * (CLK_HZ / 1_000_000) < 1) ?
                                      1 : DISCREPANCY_TIME_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LEVEL_ONE = 2'b00,
    LEVEL_TWO = 2'b01,
    LEVEL_THREE = 2'b10,
    LEVEL_FOUR = 2'b11
  } speed_level_t;

  typedef struct packed {
    logic torque_off_sel;
    logic stop_one_sel;
    logic limited_speed_sel;
    logic event_ack;
    speed_level_t level;
  } cmd_fields_t;

  typedef struct packed {
    logic power_removed;
    logic stop_one_active;
    logic limited_speed_active;
    logic internal_event;
    speed_level_t level;
  } state_fields_t;

endpackage

// ### failsafe_input_pair.sv
// Purpose: one two-channel fail-safe digital input with discrepancy check
// Assumes: both channel pins are asynchronous to CLK_SYS
// Notes: a deactivated input stays off until clear_deact is pulsed
`timescale 1ns/1ns
`default_nettype none
module failsafe_input_pair #(
  parameter int DISC_CYCLES = safety_telegram_pkg::DISCREPANCY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // channel pins
  input wire logic ch_a_pin,
  input wire logic ch_b_pin,
  // configuration and control
  input wire logic used,
  input wire logic clear_deact,
  // result
  output logic level,
  output logic deactivated
);

  localparam int CNT_W = $clog2(DISC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(DISC_CYCLES);

  logic [2:0] a_sync_q, a_sync_d;
  logic [2:0] b_sync_q, b_sync_d;
  logic a_stable_q, a_stable_d;
  logic b_stable_q, b_stable_d;
  logic [CNT_W-1:0] disc_cnt_q, disc_cnt_d;
  logic deact_q, deact_d;
  logic level_q, level_d;

  // ----------------------------------------------------------------
  // synchronise, filter, check discrepancy
  // ----------------------------------------------------------------
  always_comb begin
    a_sync_d = {a_sync_q[1:0], ch_a_pin};
    b_sync_d = {b_sync_q[1:0], ch_b_pin};
    // only stages two and three are compared; stage one feeds stage two alone
    a_stable_d = (a_sync_q[1] == a_sync_q[2]) ? a_sync_q[2] : a_stable_q;
    b_stable_d = (b_sync_q[1] == b_sync_q[2]) ? b_sync_q[2] : b_stable_q;
    disc_cnt_d = '0;
    if (used && (a_stable_q != b_stable_q) && !deact_q) begin
      disc_cnt_d = (disc_cnt_q == CNT_LIMIT) ? disc_cnt_q : disc_cnt_q + 1'b1;
    end
    deact_d = deact_q;
    if (clear_deact) begin
      deact_d = 1'b0;
    end
    // a discrepancy that matures in the clearing cycle still deactivates
    if (used && (disc_cnt_q == CNT_LIMIT)) begin
      deact_d = 1'b1;
    end
    // unused or deactivated inputs always report low
    level_d = used && !deact_q && a_stable_q && b_stable_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      a_sync_q <= 3'h0;
      b_sync_q <= 3'h0;
      a_stable_q <= 1'b0;
      b_stable_q <= 1'b0;
      disc_cnt_q <= '0;
      deact_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      a_sync_q <= a_sync_d;
      b_sync_q <= b_sync_d;
      a_stable_q <= a_stable_d;
      b_stable_q <= b_stable_d;
      disc_cnt_q <= disc_cnt_d;
      deact_q <= deact_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
  assign deactivated = deact_q;

endmodule
`default_nettype wire

// ### safety_telegram_words_assertions.sv
// Purpose: concurrent checks on the safety telegram word ports
// Assumes: one clock, synchronous active-high reset
// Notes: last acknowledge level is kept here to find the falling change
`timescale 1ns/1ns
`default_nettype none
module safety_telegram_words_assertions #(
  parameter int PAIRS = 3,
  parameter int DISC_CYCLES = 8
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // telegram
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic EXTENDED_TELEGRAM,
  input wire logic [15:0] STATE_WORD,
  input wire logic [15:0] INPUT_STATE_WORD,
  // inputs and drive status
  input wire logic [PAIRS-1:0] FAILSAFE_INPUT_USED,
  input wire logic TORQUE_SAFELY_OFF,
  input wire logic STOP_ONE_RAMPING,
  input wire logic SPEED_BELOW_LIMIT,
  input wire logic INTERNAL_FAULT_STOP,
  // requests
  input wire logic LIMITED_SPEED_REQ,
  input wire logic [1:0] LIMITED_SPEED_LEVEL,
  input wire logic EVENT_ACK_PULSE,
  input wire logic [PAIRS-1:0] FAILSAFE_INPUT_DEACT
);
  // --------------------
  // properties
  // --------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic ack_q;
  logic ack_d;
  always_comb begin
    ack_d = CMD_VALID ? CMD_WORD[7] : ack_q;
  end
  always_ff @(posedge CLK_SYS) begin
    ack_q <= RESET ? 1'b0 : ack_d;
  end
  sequence ack_fall_s;
    CMD_VALID && ack_q && !CMD_WORD[7];
  endsequence
  sequence ack_done_s;
    EVENT_ACK_PULSE && !INTERNAL_FAULT_STOP ##1 !INTERNAL_FAULT_STOP;
  endsequence
  a_basic_inputs_zero: assert property (
    !EXTENDED_TELEGRAM && !$past(EXTENDED_TELEGRAM) && !$past(EXTENDED_TELEGRAM, 2) |->
    INPUT_STATE_WORD == 16'h0000)
    else $error("input state word set in basic telegram");
  // a bit trails its use flag by two edges and the deactivation report by one
  a_inactive_zero: assert property ((INPUT_STATE_WORD[10:8] & ~(
    $past(FAILSAFE_INPUT_USED, 2) & ~$past(FAILSAFE_INPUT_DEACT))) == 3'b000)
    else $error("unused or deactivated input reads one");
  a_power_removed: assert property (
    !$past(RESET) |-> STATE_WORD[0] == $past(TORQUE_SAFELY_OFF))
    else $error("power removed bit wrong");
  a_stop_ramp: assert property (STATE_WORD[1] |-> $past(STOP_ONE_RAMPING))
    else $error("stop one active without ramp");
  a_limit_active: assert property (STATE_WORD[4] |->
    $past(SPEED_BELOW_LIMIT) && $past(LIMITED_SPEED_REQ))
    else $error("limit active bit wrong");
  a_level_report: assert property (
    STATE_WORD[4] |-> STATE_WORD[10:9] == $past(LIMITED_SPEED_LEVEL))
    else $error("active level differs from request");
  a_event_set: assert property (INTERNAL_FAULT_STOP |-> ##2 STATE_WORD[7])
    else $error("internal event bit not set");
  a_ack_pulse: assert property (ack_fall_s |=> EVENT_ACK_PULSE ##1 !EVENT_ACK_PULSE)
    else $error("acknowledge pulse missing or long");
  a_ack_cause: assert property (
    EVENT_ACK_PULSE |-> $past(CMD_VALID && ack_q && !CMD_WORD[7]))
    else $error("acknowledge pulse without falling ack");
  a_event_clear: assert property (ack_done_s |=> !STATE_WORD[7])
    else $error("internal event not cleared");
endmodule
bind safety_telegram_words safety_telegram_words_assertions #(
  .PAIRS(PAIRS),
  .DISC_CYCLES(DISC_CYCLES)
) chk (
  .CLK_SYS, .RESET, .CMD_VALID, .CMD_WORD, .EXTENDED_TELEGRAM, .STATE_WORD,
  .INPUT_STATE_WORD, .FAILSAFE_INPUT_USED, .TORQUE_SAFELY_OFF, .STOP_ONE_RAMPING,
  .SPEED_BELOW_LIMIT, .INTERNAL_FAULT_STOP, .LIMITED_SPEED_REQ, .LIMITED_SPEED_LEVEL,
  .EVENT_ACK_PULSE, .FAILSAFE_INPUT_DEACT
);
`default_nettype wire

// ### safety_plc_model.sv
// Purpose: controller end of the safety telegram, command side
// Assumes: the block samples the telegram on rising clk
// Notes: drives at falling edges only, one word per send call, two per acknowledge call
`timescale 1ns/1ns
`default_nettype none
module safety_plc_model #(
  // safety program cycle, in clock cycles
  parameter int PROGRAM_CYCLES = 4,
  // safety_watchdog_time kept above the program cycle
  parameter int SAFETY_WATCHDOG_TIME = PROGRAM_CYCLES + 2,
  // destination address; value arbitrary, must differ per inverter
  parameter logic [15:0] DEST_ADDR = 16'h0001
) (
  // clock
  input wire logic clk,
  // telegram out
  output logic valid,
  output logic [15:0] word,
  output logic [15:0] word_two
);
  // --------------------
  // telegram driver
  // --------------------
  initial begin
    valid = 1'b0;
    word = 16'h0000;
    word_two = 16'h0000;
  end
  // select arguments are active high; the word carries the inverse
  task automatic send(input logic safe_torque_off, input logic ss1, input logic safely_limited_speed, input logic ack,
                      input logic [1:0] lvl);
    @(negedge clk);
    valid = 1'b1;
    word = {5'h00, lvl, 1'b0, ack, 2'b00, ~safely_limited_speed, 2'b00, ~ss1, ~safe_torque_off};
    @(negedge clk);
    valid = 1'b0;
    // stale word is scrambled so nothing can lean on it
    word = ~word;
  endtask
  task automatic acknowledge(input logic safe_torque_off, input logic ss1, input logic safely_limited_speed,
                             input logic [1:0] lvl);
    send(safe_torque_off, ss1, safely_limited_speed, 1'b1, lvl);
    send(safe_torque_off, ss1, safely_limited_speed, 1'b0, lvl);
  endtask
endmodule
`default_nettype wire

// ### safety_telegram_words_tb.sv
// Purpose: self-checking bench for the safety telegram words
// Assumes: inputs change on falling clk, discrepancy count shortened to 8
// Notes: controller side comes from safety_plc_model
`timescale 1ns/1ns
`default_nettype none
module safety_telegram_words_tb;
  // --------------------
  // harness
  // --------------------
  logic clk = 1'b0, rst = 1'b1, ext = 1'b1;
  logic [2:0] cha = 3'b000, chb = 3'b000, used = 3'b111, deact;
  logic tso = 1'b0, ramp = 1'b0, below = 1'b0, fault = 1'b0;
  logic valid, sto_r, ss1_r, sls_r, ackp;
  logic [15:0] word, word2, state, inw;
  logic [1:0] lvl;
  int err_count = 0, checks_done = 0, cycles = 0;
  safety_plc_model plc (.clk(clk), .valid(valid), .word(word), .word_two(word2));
  safety_telegram_words #(.DISC_CYCLES(8)) dut (
    .CLK_SYS(clk), .RESET(rst), .CMD_VALID(valid), .CMD_WORD(word), .CMD_WORD_TWO(word2),
    .EXTENDED_TELEGRAM(ext), .STATE_WORD(state), .INPUT_STATE_WORD(inw),
    .FAILSAFE_CH_A(cha), .FAILSAFE_CH_B(chb), .FAILSAFE_INPUT_USED(used),
    .TORQUE_SAFELY_OFF(tso), .STOP_ONE_RAMPING(ramp), .SPEED_BELOW_LIMIT(below),
    .INTERNAL_FAULT_STOP(fault), .SAFE_TORQUE_OFF_REQ(sto_r), .SAFE_STOP_ONE_REQ(ss1_r),
    .LIMITED_SPEED_REQ(sls_r), .LIMITED_SPEED_LEVEL(lvl), .EVENT_ACK_PULSE(ackp),
    .FAILSAFE_INPUT_DEACT(deact));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset();
    chk(state, 16'h0000);
    chk(inw, 16'h0000);
    chk(sto_r, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_levels();
    for (int l = 0; l < 4; l++) begin
      plc.send(1'b0, 1'b1, 1'b0, 1'b0, l[1:0]);
      idle(1);
      chk(lvl, l[1:0]);
      below = 1'b1;
      plc.send(1'b0, 1'b1, 1'b1, 1'b0, l[1:0]);
      idle(2);
      chk(state[10:9], l[1:0]);
      chk(state[4], 1'b1);
      chk({sto_r, ss1_r, sls_r}, 3'b011);
      below = 1'b0;
      idle(2);
      chk(state[4], 1'b0);
    end
    $display("test levels done");
  endtask
  task automatic t_status();
    tso = 1'b1;
    ramp = 1'b1;
    idle(2);
    chk(state[0], 1'b1);
    chk(state[1], 1'b1);
    tso = 1'b0;
    ramp = 1'b0;
    idle(2);
    chk(state[1:0], 2'b00);
    $display("test status done");
  endtask
  task automatic t_event();
    fault = 1'b1;
    idle(1);
    fault = 1'b0;
    idle(3);
    chk(state[7], 1'b1);
    // a held-high ack must not clear the event
    plc.send(1'b0, 1'b1, 1'b1, 1'b1, 2'b11);
    idle(3);
    chk(state[7], 1'b1);
    plc.acknowledge(1'b0, 1'b1, 1'b1, 2'b11);
    chk(ackp, 1'b1);
    idle(1);
    chk(ackp, 1'b0);
    idle(3);
    chk(state[7], 1'b0);
    $display("test event done");
  endtask
  task automatic t_fault_hold();
    // a fault held through the acknowledge keeps the flag set
    fault = 1'b1;
    plc.acknowledge(1'b0, 1'b1, 1'b1, 2'b11);
    idle(1);
    fault = 1'b0;
    idle(3);
    chk(state[7], 1'b1);
    $display("test fault hold done");
  endtask
  task automatic t_pairs();
    for (int i = 0; i < 3; i++) begin
      cha[i] = 1'b1;
      chb[i] = 1'b1;
      idle(8);
      chk(inw, 16'h0100 << i);
      used[i] = 1'b0;
      idle(4);
      chk(inw, 16'h0000);
      used[i] = 1'b1;
      cha[i] = 1'b0;
      chb[i] = 1'b0;
      idle(8);
      chk(inw, 16'h0000);
    end
    cha[0] = 1'b1;
    idle(20);
    chk(deact, 3'b001);
    chb[0] = 1'b1;
    idle(8);
    chk(inw, 16'h0000);
    plc.acknowledge(1'b0, 1'b1, 1'b1, 2'b11);
    idle(8);
    chk(inw, 16'h0100);
    cha[0] = 1'b0;
    chb[0] = 1'b0;
    $display("test pairs done");
  endtask
  task automatic t_basic();
    ext = 1'b0;
    cha[1] = 1'b1;
    chb[1] = 1'b1;
    idle(8);
    chk(inw, 16'h0000);
    plc.send(1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
    idle(1);
    chk({ss1_r, sls_r}, 2'b00);
    ext = 1'b1;
    idle(8);
    chk(inw, 16'h0200);
    $display("test basic done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    idle(2);
    t_reset();
    t_levels();
    t_status();
    t_event();
    t_fault_hold();
    t_pairs();
    t_basic();
    summarize();
  end
endmodule
`default_nettype wire
